// [rtl/ddp_consts.svh]
/*
 memory port constants: widths, capacity, rate limits, reset values.
 assumes inclusion by bare name from the package and the modules.
*/
`ifndef DDP_CONSTS_SVH
`define DDP_CONSTS_SVH
`define DDP_DQ_WIDTH        16
`define DDP_STROBE_WIDTH    2
`define DDP_MEM_MBITS       256
`define DDP_MEM_CLK_MAX_MHZ 200
`define DDP_LINE_MAX_MBPS   400
`define DDP_FIFO_DEPTH      16
`define DDP_PIN_RESET_N_RST 1'b0
`define DDP_PIN_SELECT_RST  1'b1
`endif

// [rtl/ddp_pkg.sv]
/*
 types shared by the memory port modules.
 assumes the constants header sits on the include path.
*/
`include "ddp_consts.svh"
package ddp_pkg;
   // input capture sequencer states
   typedef enum logic [1:0]
   {
      DDP_CAP_HIGH = 2'b00,
      DDP_CAP_LOW  = 2'b01,
      DDP_CAP_PUSH = 2'b10
   } ddp_cap_t;
endpackage : ddp_pkg

// [rtl/ddp_fifo.sv]
/*
 synchronous fifo with valid and ready on both sides.
 assumes one clock and a synchronised active-low reset.
*/
`timescale 1ns/1ps
`include "ddp_consts.svh"
module ddp_fifo
   import ddp_pkg::*;
#(
   parameter int WIDTH = 36,
   parameter int DEPTH = `DDP_FIFO_DEPTH
)
(
   // clock and reset
   input  wire logic             i_clk,
   input  wire logic             i_rst_n,
   // fill side
   input  wire logic             i_in_valid,
   input  wire logic [WIDTH-1:0] i_in_data,
   output wire logic             o_in_ready,
   // drain side
   output wire logic             o_out_valid,
   output wire logic [WIDTH-1:0] o_out_data,
   input  wire logic             i_out_ready
);
   localparam int PW = $clog2(DEPTH);
   localparam int CW = $clog2(DEPTH + 1);
   localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);
   localparam logic [CW-1:0] FULL = CW'(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [PW-1:0]    wr_ptr_r;
   logic [PW-1:0]    rd_ptr_r;
   logic [CW-1:0]    count_r;
   wire              push;
   wire              pop;

   // honest full and empty from the fill count
   assign o_in_ready  = (count_r != FULL);
   assign o_out_valid = (count_r != '0);
   assign o_out_data  = mem[rd_ptr_r];
   assign push        = i_in_valid && o_in_ready;
   assign pop         = o_out_valid && i_out_ready;

   // storage write
   always_ff @(posedge i_clk)
   begin
      if (push)
         mem[wr_ptr_r] <= i_in_data;
   end

   // pointers and count
   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
         count_r  <= '0;
      end
      else
      begin
         if (push)
            wr_ptr_r <= (wr_ptr_r == LAST) ? '0 : wr_ptr_r + 1'b1;
         if (pop)
            rd_ptr_r <= (rd_ptr_r == LAST) ? '0 : rd_ptr_r + 1'b1;
         if (push && !pop)
            count_r <= count_r + 1'b1;
         else if (pop && !push)
            count_r <= count_r - 1'b1;
      end
   end
endmodule : ddp_fifo

// [rtl/ddp_port.sv]
/*
 fabric-side port to a packaged 16-bit double-data-rate memory die:
 output ddr registers for clock, strobe/mask and data, a once-per-pair select register, and an
 input capture path timed by the calibration clock into a fifo.
 assumes user-side inputs come from logic on i_clk; memory pins, the
 quadrature clock and the calibration clock are asynchronous.
*/
`timescale 1ns/1ps
`include "ddp_consts.svh"
// Contract
// - The memory holds 256 Mbits and its clock must not exceed 200 MHz.
// - Data moves on a 16-bit bus at double rate, at most 400 Mbps a line.
// - The memory clock is sent as high and low halves on both legs.
// - The strobe from the memory is returned as high and low halves.
// - Read data from the 16 lines is delivered as high and low halves.
module ddp_port
   import ddp_pkg::*;
#(
   parameter int DQW = `DDP_DQ_WIDTH,
   parameter int SW  = `DDP_STROBE_WIDTH
)
(
   // clock and reset
   input  wire logic           i_clk,
   input  wire logic           i_resetn,
   // user control
   input  wire logic           i_mem_reset_n,
   input  wire logic           i_mem_select_n,
   input  wire logic           i_mem_clock_true_high_half,
   input  wire logic           i_mem_clock_true_low_half,
   input  wire logic           i_mem_clock_comp_high_half,
   input  wire logic           i_mem_clock_comp_low_half,
   // user write side
   input  wire logic [SW-1:0]  i_strobe_mask_out_high,
   input  wire logic [SW-1:0]  i_strobe_mask_out_low,
   input  wire logic [SW-1:0]  i_strobe_drive_enable,
   input  wire logic [DQW-1:0] i_bus_out_high_half,
   input  wire logic [DQW-1:0] i_bus_out_low_half,
   input  wire logic [DQW-1:0] i_bus_drive_enable,
   // auxiliary clocks
   input  wire logic           i_quadrature_clock,
   input  wire logic           i_input_calibration_clock,
   // memory pins, input side
   input  wire logic [DQW-1:0] i_pin_dq,
   input  wire logic [SW-1:0]  i_pin_strobe,
   // memory pins, output side
   output logic                o_pin_reset_n,
   output logic                o_pin_select_n,
   output logic                o_pin_ck_true,
   output logic                o_pin_ck_comp,
   output logic [DQW-1:0]      o_pin_dq,
   output logic [DQW-1:0]      o_pin_dq_oe,
   output logic [SW-1:0]       o_pin_strobe,
   output logic [SW-1:0]       o_pin_strobe_oe,
   // user read side
   output logic [DQW-1:0]      o_bus_in_high_half,
   output logic [DQW-1:0]      o_bus_in_low_half,
   output logic [SW-1:0]       o_strobe_return_high,
   output logic [SW-1:0]       o_strobe_return_low,
   output logic                o_rd_valid,
   input  wire logic           i_rd_ready,
   output logic                o_capture_ready,
   output logic                o_quad_level
);
   localparam int HW = DQW + SW;
   localparam int FW = 2 * HW;

   // reset release through two flops
   logic rst_s1_r;
   logic rst_n;
   always_ff @(posedge i_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         rst_s1_r <= 1'b0;
         rst_n    <= 1'b0;
      end
      else
      begin
         rst_s1_r <= 1'b1;
         rst_n    <= rst_s1_r;
      end
   end

   // output ddr register: phase 0 sends high half, phase 1 low half
   logic           out_phase_r;
   logic [DQW-1:0] dq_lo_hold_r;
   logic [SW-1:0]  st_lo_hold_r;
   logic           ckt_lo_hold_r;
   logic           ckc_lo_hold_r;
   always_ff @(posedge i_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         out_phase_r     <= 1'b0;
         dq_lo_hold_r    <= '0;
         st_lo_hold_r    <= '0;
         ckt_lo_hold_r   <= 1'b0;
         ckc_lo_hold_r   <= 1'b0;
         o_pin_dq        <= '0;
         o_pin_dq_oe     <= '0;
         o_pin_strobe    <= '0;
         o_pin_strobe_oe <= '0;
         o_pin_ck_true   <= 1'b0;
         o_pin_ck_comp   <= 1'b0;
         o_pin_reset_n   <= `DDP_PIN_RESET_N_RST;
         o_pin_select_n  <= `DDP_PIN_SELECT_RST;
      end
      else
      begin
         out_phase_r <= ~out_phase_r;
         if (!out_phase_r)
         begin
            o_pin_dq        <= i_bus_out_high_half;
            o_pin_strobe    <= i_strobe_mask_out_high;
            o_pin_ck_true   <= i_mem_clock_true_high_half;
            o_pin_ck_comp   <= i_mem_clock_comp_high_half;
            dq_lo_hold_r    <= i_bus_out_low_half;
            st_lo_hold_r    <= i_strobe_mask_out_low;
            ckt_lo_hold_r   <= i_mem_clock_true_low_half;
            ckc_lo_hold_r   <= i_mem_clock_comp_low_half;
            o_pin_dq_oe     <= i_bus_drive_enable;
            o_pin_strobe_oe <= i_strobe_drive_enable;
            o_pin_reset_n   <= i_mem_reset_n;
            o_pin_select_n  <= i_mem_select_n;
         end
         else
         begin
            o_pin_dq      <= dq_lo_hold_r;
            o_pin_strobe  <= st_lo_hold_r;
            o_pin_ck_true <= ckt_lo_hold_r;
            o_pin_ck_comp <= ckc_lo_hold_r;
         end
      end
   end

   // synchronisers for asynchronous inputs
   logic           cal_s1_r, cal_s2_r, cal_s3_r;
   logic           quad_s1_r;
   logic [DQW-1:0] dq_s1_r, dq_s2_r;
   logic [SW-1:0]  st_s1_r, st_s2_r;
   always_ff @(posedge i_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cal_s1_r     <= 1'b0;
         cal_s2_r     <= 1'b0;
         cal_s3_r     <= 1'b0;
         quad_s1_r    <= 1'b0;
         o_quad_level <= 1'b0;
         dq_s1_r      <= '0;
         dq_s2_r      <= '0;
         st_s1_r      <= '0;
         st_s2_r      <= '0;
      end
      else
      begin
         cal_s1_r     <= i_input_calibration_clock;
         cal_s2_r     <= cal_s1_r;
         cal_s3_r     <= cal_s2_r;
         quad_s1_r    <= i_quadrature_clock;
         o_quad_level <= quad_s1_r;
         dq_s1_r      <= i_pin_dq;
         dq_s2_r      <= dq_s1_r;
         st_s1_r      <= i_pin_strobe;
         st_s2_r      <= st_s1_r;
      end
   end

   // calibration clock edges
   wire cal_rise = cal_s2_r && !cal_s3_r;
   wire cal_fall = !cal_s2_r && cal_s3_r;

   // capture sequencer: rise gives high half, fall gives low half
   ddp_cap_t      cap_state_r;
   ddp_cap_t      cap_state_nxt;
   logic [HW-1:0] cap_hi_r;
   logic [HW-1:0] cap_lo_r;
   wire           fifo_in_ready;
   wire           fifo_in_valid = (cap_state_r == DDP_CAP_PUSH);
   always_comb
   begin
      cap_state_nxt = cap_state_r;
      unique case (cap_state_r)
         DDP_CAP_HIGH: if (cal_rise) cap_state_nxt = DDP_CAP_LOW;
         DDP_CAP_LOW:  if (cal_fall) cap_state_nxt = DDP_CAP_PUSH;
         DDP_CAP_PUSH: if (fifo_in_ready) cap_state_nxt = DDP_CAP_HIGH;
         default:      cap_state_nxt = DDP_CAP_HIGH;
      endcase
   end

   always_ff @(posedge i_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cap_state_r <= DDP_CAP_HIGH;
         cap_hi_r    <= '0;
         cap_lo_r    <= '0;
      end
      else
      begin
         cap_state_r <= cap_state_nxt;
         if (cap_state_r == DDP_CAP_HIGH && cal_rise)
            cap_hi_r <= {st_s2_r, dq_s2_r};
         if (cap_state_r == DDP_CAP_LOW && cal_fall)
            cap_lo_r <= {st_s2_r, dq_s2_r};
      end
   end

   // read fifo and registered output stage
   wire           fifo_out_valid;
   wire [FW-1:0]  fifo_out_data;
   wire           stage_ready = !o_rd_valid || i_rd_ready;
   ddp_fifo #(.WIDTH(FW), .DEPTH(`DDP_FIFO_DEPTH)) u_fifo
   (
      .i_clk       (i_clk),
      .i_rst_n     (rst_n),
      .i_in_valid  (fifo_in_valid),
      .i_in_data   ({cap_hi_r, cap_lo_r}),
      .o_in_ready  (fifo_in_ready),
      .o_out_valid (fifo_out_valid),
      .o_out_data  (fifo_out_data),
      .i_out_ready (stage_ready)
   );

   always_ff @(posedge i_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         o_rd_valid           <= 1'b0;
         o_bus_in_high_half   <= '0;
         o_bus_in_low_half    <= '0;
         o_strobe_return_high <= '0;
         o_strobe_return_low  <= '0;
         o_capture_ready      <= 1'b0;
      end
      else
      begin
         o_capture_ready <= fifo_in_ready;
         if (stage_ready)
         begin
            o_rd_valid <= fifo_out_valid;
            {o_strobe_return_high, o_bus_in_high_half,
             o_strobe_return_low, o_bus_in_low_half} <= fifo_out_data;
         end
      end
   end

   a_high_half_first: assert property (@(posedge i_clk)
      disable iff (!rst_n)
      !out_phase_r |=> o_pin_dq == $past(i_bus_out_high_half))
      else $error("high half not sent first");
   a_low_half_next: assert property (@(posedge i_clk)
      disable iff (!rst_n)
      !out_phase_r ##1 out_phase_r |=> o_pin_dq == $past(i_bus_out_low_half, 2))
      else $error("low half not sent second");
   a_ck_pair_order: assert property (@(posedge i_clk)
      disable iff (!rst_n)
      !out_phase_r |=> o_pin_ck_true == $past(i_mem_clock_true_high_half)
         ##1 o_pin_ck_comp == $past(i_mem_clock_comp_low_half, 2))
      else $error("memory clock halves out of order");
   a_oe_pair_hold: assert property (@(posedge i_clk)
      disable iff (!rst_n)
      out_phase_r |=> $stable(o_pin_dq_oe))
      else $error("data enable changed inside a pair");
   a_phase_alternates: assert property (@(posedge i_clk)
      disable iff (!rst_n)
      out_phase_r |=> !out_phase_r ##1 out_phase_r)
      else $error("output phase did not alternate");
   a_rise_loads_high: assert property (@(posedge i_clk)
      disable iff (!rst_n)
      cap_state_r == DDP_CAP_HIGH && cal_rise |=>
         cap_hi_r == $past({st_s2_r, dq_s2_r}) && cap_state_r == DDP_CAP_LOW)
      else $error("rising edge did not load high half");
   a_fall_then_push: assert property (@(posedge i_clk)
      disable iff (!rst_n)
      cap_state_r == DDP_CAP_LOW && cal_fall |=> fifo_in_valid
         && cap_lo_r == $past({st_s2_r, dq_s2_r}))
      else $error("falling edge did not queue a pair");
   a_read_hold: assert property (@(posedge i_clk)
      disable iff (!rst_n)
      o_rd_valid && !i_rd_ready |=> o_rd_valid && $stable(o_bus_in_high_half)
         && $stable(o_bus_in_low_half))
      else $error("read word changed while stalled");
endmodule : ddp_port

// [dv/ddp_mem_model.sv]
/*
 read-side model of the packaged memory die.
 assumes the bench resolves each pin from the port's enables and this
 drive, and runs the calibration clock only inside a burst.
*/
`timescale 1ns/1ps
module ddp_mem_model
#(
   parameter logic [15:0] BASE = 16'h3C00
)
(
   // calibration clock and select as seen on the pins
   input  wire logic   i_cal,
   input  wire logic   i_select_n,
   // read return toward the port
   output logic [15:0] o_dq,
   output logic [1:0]  o_strobe
);
   int unsigned idx;

   // word n of a burst
   function automatic logic [15:0] word(input int unsigned n);
      return BASE ^ 16'(n * 32'h0301);
   endfunction : word

   // idle levels
   initial
   begin
      idx      = 0;
      o_dq     = 16'h0000;
      o_strobe = 2'b00;
   end

   // burst start: first word, strobe high
   always @(negedge i_select_n)
   begin
      idx      = 0;
      o_dq     = word(0);
      o_strobe = 2'b11;
   end

   // new word well clear of each calibration edge
   always @(i_cal)
   begin
      if (!i_select_n)
      begin
         #300;
         idx      = idx + 1;
         o_dq     = word(idx);
         o_strobe = {2{~idx[0]}};
      end
   end

   // released lines show the inverse so stale data cannot match
   always @(posedge i_select_n)
   begin
      o_dq     = ~o_dq;
      o_strobe = ~o_strobe;
   end
endmodule : ddp_mem_model

// [dv/tb_top.sv]
/*
 self-checking bench for the memory port: reset levels, output pairs,
 quadrature level, read capture through the fifo with a stalled reader.
 assumes the memory model file and the design files are compiled first.
*/
`timescale 1ns/1ps
module tb_top;
   // user-side drive
   logic        i_clk, i_resetn, i_mem_reset_n, i_mem_select_n;
   logic        i_mem_clock_true_high_half, i_mem_clock_true_low_half;
   logic        i_mem_clock_comp_high_half, i_mem_clock_comp_low_half;
   logic [1:0]  i_strobe_mask_out_high, i_strobe_mask_out_low;
   logic [1:0]  i_strobe_drive_enable;
   logic [15:0] i_bus_out_high_half, i_bus_out_low_half, i_bus_drive_enable;
   logic        i_quadrature_clock, i_input_calibration_clock, i_rd_ready;
   // design outputs
   logic        o_pin_reset_n, o_pin_select_n, o_pin_ck_true, o_pin_ck_comp;
   logic [15:0] o_pin_dq, o_pin_dq_oe, o_bus_in_high_half, o_bus_in_low_half;
   logic [1:0]  o_pin_strobe, o_pin_strobe_oe;
   logic [1:0]  o_strobe_return_high, o_strobe_return_low;
   logic        o_rd_valid, o_capture_ready, o_quad_level;
   // model drive and resolved pin levels
   logic [15:0] m_dq;
   logic [1:0]  m_strobe;
   wire  [15:0] i_pin_dq = (o_pin_dq_oe & o_pin_dq) | (~o_pin_dq_oe & m_dq);
   wire  [1:0]  i_pin_strobe = (o_pin_strobe_oe & o_pin_strobe)
                             | (~o_pin_strobe_oe & m_strobe);
   wire  [19:0] pins = {o_pin_dq, o_pin_ck_true, o_pin_ck_comp, o_pin_strobe};
   int          n_mismatch, tests_run;

   ddp_port u_dut
   (
      .i_clk, .i_resetn, .i_mem_reset_n, .i_mem_select_n,
      .i_mem_clock_true_high_half, .i_mem_clock_true_low_half,
      .i_mem_clock_comp_high_half, .i_mem_clock_comp_low_half,
      .i_strobe_mask_out_high, .i_strobe_mask_out_low,
      .i_strobe_drive_enable, .i_bus_out_high_half, .i_bus_out_low_half,
      .i_bus_drive_enable, .i_quadrature_clock, .i_input_calibration_clock,
      .i_pin_dq, .i_pin_strobe, .o_pin_reset_n, .o_pin_select_n,
      .o_pin_ck_true, .o_pin_ck_comp, .o_pin_dq, .o_pin_dq_oe,
      .o_pin_strobe, .o_pin_strobe_oe, .o_bus_in_high_half,
      .o_bus_in_low_half, .o_strobe_return_high, .o_strobe_return_low,
      .o_rd_valid, .i_rd_ready, .o_capture_ready, .o_quad_level
   );

   ddp_mem_model u_mem
   (
      .i_cal      (i_input_calibration_clock),
      .i_select_n (o_pin_select_n),
      .o_dq       (m_dq),
      .o_strobe   (m_strobe)
   );

   // 100 ns clock
   initial
   begin
      i_clk = 1'b0;
      forever #50 i_clk = ~i_clk;
   end

   // one comparison, counted
   task automatic chk(input string what, input logic [39:0] exp,
                      input logic [39:0] got);
      tests_run++;
      if (got !== exp)
      begin
         $display("ERROR %s expected %h seen %h", what, exp, got);
         n_mismatch++;
      end
   endtask : chk

   // expected read word n
   function automatic logic [15:0] ew(input int n);
      return 16'h3C00 ^ 16'(n * 32'h0301);
   endfunction : ew

   // output pairs under changing data, masks, enables and control
   task automatic t_pairs;
      logic [19:0] hs, ls;
      for (int k = 0; k < 3; k++)
      begin
         @(posedge i_clk);
         i_bus_out_high_half    <= 16'hA5F0 ^ 16'(k * 32'h1357);
         i_bus_out_low_half     <= 16'h0F3C ^ 16'(k * 32'h2468);
         i_strobe_mask_out_high <= 2'(k + 1);
         i_strobe_mask_out_low  <= 2'(k + 2);
         i_bus_drive_enable     <= (k == 2) ? 16'h00FF : 16'hFFFF;
         i_strobe_drive_enable  <= 2'(k + 1);
         i_mem_select_n         <= k[0];
         i_mem_reset_n          <= (k != 1);
         hs = {16'hA5F0 ^ 16'(k * 32'h1357), 2'b10, 2'(k + 1)};
         ls = {16'h0F3C ^ 16'(k * 32'h2468), 2'b01, 2'(k + 2)};
         repeat (4) @(posedge i_clk);
         @(negedge i_clk);
         if (pins !== hs) @(negedge i_clk);
         chk("pair_high", hs, pins);
         @(negedge i_clk);
         chk("pair_low", ls, pins);
         chk("pin_ctl", {(k == 2) ? 16'h00FF : 16'hFFFF, 2'(k + 1),
             k != 1, k[0]}, {o_pin_dq_oe, o_pin_strobe_oe, o_pin_reset_n,
             o_pin_select_n});
      end
   endtask : t_pairs

   // quadrature level follows its input
   task automatic t_quad;
      for (int k = 0; k < 2; k++)
      begin
         @(posedge i_clk) i_quadrature_clock <= ~k[0];
         repeat (4) @(posedge i_clk);
         @(negedge i_clk) chk("quad_level", !k[0], o_quad_level);
      end
   endtask : t_quad

   // 17 pairs against a stalled reader, then drain in order
   task automatic t_fill;
      int w;
      @(posedge i_clk);
      i_bus_drive_enable    <= 16'h0000;
      i_strobe_drive_enable <= 2'b00;
      i_mem_select_n        <= 1'b0;
      i_rd_ready            <= 1'b0;
      repeat (6) @(posedge i_clk);
      #37;
      // calibration clock, 800 ns, only within the burst
      repeat (34)
      begin
         i_input_calibration_clock = ~i_input_calibration_clock;
         #400;
      end
      repeat (10) @(posedge i_clk);
      i_mem_select_n <= 1'b1;
      @(negedge i_clk) chk("fifo_full", 2'b01, {o_capture_ready, o_rd_valid});
      @(posedge i_clk) i_rd_ready <= 1'b1;
      for (int k = 0; k < 17; k++)
      begin
         w = 0;
         @(negedge i_clk);
         while (o_rd_valid !== 1'b1 && w < 20)
         begin
            @(negedge i_clk);
            w++;
         end
         chk("read_pair", {1'b1, ew(2 * k), ew(2 * k + 1), 4'hC},
             {o_rd_valid, o_bus_in_high_half, o_bus_in_low_half,
              o_strobe_return_high, o_strobe_return_low});
         @(posedge i_clk);
      end
      repeat (3) @(negedge i_clk);
      chk("fifo_empty", 2'b10, {o_capture_ready, o_rd_valid});
   endtask : t_fill

   // verdict and end of run
   task automatic end_of_test;
      $display("mismatches %0d comparisons %0d", n_mismatch, tests_run);
      if (n_mismatch == 0 && tests_run > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : end_of_test

   // main sequence
   initial
   begin
      {i_resetn, i_mem_reset_n, i_mem_clock_true_low_half,
       i_mem_clock_comp_high_half, i_strobe_mask_out_high,
       i_strobe_mask_out_low, i_strobe_drive_enable, i_bus_out_high_half,
       i_bus_out_low_half, i_bus_drive_enable, i_quadrature_clock,
       i_input_calibration_clock, i_rd_ready} = '0;
      i_mem_select_n             = 1'b1;
      i_mem_clock_true_high_half = 1'b1;
      i_mem_clock_comp_low_half  = 1'b1;
      repeat (3) @(posedge i_clk);
      @(negedge i_clk);
      chk("reset_pins", {19'h0, 2'b01}, {o_pin_dq_oe, o_pin_strobe_oe,
          o_rd_valid, o_pin_reset_n, o_pin_select_n});
      @(posedge i_clk) i_resetn <= 1'b1;
      repeat (4) @(posedge i_clk);
      t_pairs;
      t_quad;
      t_fill;
      end_of_test;
   end

   // hang guard: the run needs well under 4000 cycles
   initial
   begin
      #400000;
      n_mismatch++;
      end_of_test;
   end
endmodule : tb_top
